//--- hw/cmcd_pkg.sv
/*
  Shared constants and types for the conflict monitor channel display block:
  register offsets, field positions, reset values, timing counts and state codes.
  Assumes a 10 MHz system clock and sixteen monitored channels.
*/
package cmcd_pkg;

  // ------------------------------------------------------------------
  // geometry
  // ------------------------------------------------------------------
  localparam int NCH = 16;
  localparam int NPAIR = 120;
  localparam int NCLS = 3;

  // ------------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CHSEL = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_DISP = 8'h0C;
  localparam int CTRL_THREE_BIT = 0;
  localparam int CTRL_SFPOL_BIT = 1;
  localparam int STAT_CAUSE_LSB = 0;
  localparam int STAT_FAILED_BIT = 3;
  localparam int STAT_EXT_BIT = 4;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [15:0] CHSEL_RESET = 16'h0000;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_NS = 100;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYCLES_DEF = TICK_NS / CLK_NS;
  localparam int TICK_W = 14;
  localparam int TICK_MS = 1;
  localparam int PERSIST_MS = 300;
  localparam int CONFLICT_IGNORE_MS = 200;
  localparam int CONFLICT_FAIL_MS = 450;
  localparam logic [8:0] PERSIST_TICKS = 9'(PERSIST_MS / TICK_MS);

  // ------------------------------------------------------------------
  // states and fault causes
  // ------------------------------------------------------------------
  typedef enum logic {
    CMCD_ST_RUN = 1'b0,
    CMCD_ST_FAILED = 1'b1
  } cmcd_state_t;

  typedef enum logic [2:0] {
    CMCD_CAUSE_NONE = 3'b000,
    CMCD_CAUSE_DC = 3'b001,
    CMCD_CAUSE_CONFLICT = 3'b010,
    CMCD_CAUSE_WDT = 3'b011,
    CMCD_CAUSE_CARD = 3'b100,
    CMCD_CAUSE_NOOUT = 3'b101,
    CMCD_CAUSE_MULT = 3'b110,
    CMCD_CAUSE_GAP = 3'b111
  } cmcd_cause_t;

endpackage : cmcd_pkg

//--- hw/cmcd_monitor.sv
/*
  Channel status and feature gating of a cabinet conflict monitor: qualifies
  conflicts by duration, gates extended checks, drives channel indicators live,
  from a fault-time snapshot or as a faulty-channel mask. Assumes field pins arrive asynchronously and
  are level-sensed already, and an APB master on pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module cmcd_monitor #(
  parameter int TICK_CYCLES = cmcd_pkg::TICK_CYCLES_DEF
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // field and cabinet pins
  input wire logic [cmcd_pkg::NCH-1:0] green_in,
  input wire logic [cmcd_pkg::NCH-1:0] yellow_in,
  input wire logic [cmcd_pkg::NCH-1:0] red_in,
  input wire logic [cmcd_pkg::NPAIR-1:0] card_link,
  input wire logic red_enable,
  input wire logic preempt_inhibit_in,
  input wire logic flash_relay_sense,
  input wire logic dc_supply_fault,
  input wire logic watchdog_timeout_fault,
  input wire logic card_unseated_fault,
  input wire logic external_reset,
  // indicators
  output logic [cmcd_pkg::NCH-1:0] ind_single,
  output logic [cmcd_pkg::NCH-1:0] ind_red,
  output logic [cmcd_pkg::NCH-1:0] ind_yellow,
  output logic [cmcd_pkg::NCH-1:0] ind_green,
  output logic failed
);
  import cmcd_pkg::*;

  localparam int PW = 3 * NCH + NPAIR + 7;

  // ------------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------------
  function automatic logic is_linked(input logic [NPAIR-1:0] l, input int i, input int j);
    int k;
    k = i * (2 * NCH - i - 1) / 2 + j - i - 1;
    return l[k];
  endfunction : is_linked

  function automatic logic is_mapped(input logic [7:0] a);
    return (a == ADDR_CTRL) || (a == ADDR_CHSEL) || (a == ADDR_STAT) || (a == ADDR_DISP);
  endfunction : is_mapped

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  // spare input unused: the second special function has no port at all
  logic [PW-1:0] sync1;
  logic [PW-1:0] sync2;
  logic [NCH-1:0] grn, yel, red;
  logic [NPAIR-1:0] link;
  logic red_en, sf1_raw, flash, dc_f, wdt_f, card_f, ext_rst;

  // two flops on every field and cabinet pin before use; the apb pins are used directly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {green_in, yellow_in, red_in, card_link, red_enable, preempt_inhibit_in,
                flash_relay_sense, dc_supply_fault, watchdog_timeout_fault,
                card_unseated_fault, external_reset};
      sync2 <= sync1;
    end
  end

  assign {grn, yel, red, link, red_en, sf1_raw, flash, dc_f, wdt_f, card_f, ext_rst} = sync2;

  // ------------------------------------------------------------------
  // apb registers
  // ------------------------------------------------------------------
  logic [1:0] ctrl, next_ctrl;
  logic [NCH-1:0] chsel, next_chsel;
  logic next_pready, next_pslverr;
  logic [31:0] next_prdata;
  cmcd_state_t st, next_st;
  cmcd_cause_t cause, next_cause;
  logic ext_on;

  // one wait state, write lands on the completing edge
  always_comb begin
    next_ctrl = ctrl;
    next_chsel = chsel;
    next_pready = psel && penable && !pready;
    next_pslverr = next_pready && !is_mapped(paddr);
    next_prdata = 32'h00000000;
    if (next_pready && !pwrite) begin
      case (paddr)
        ADDR_CTRL: next_prdata = {30'h0, ctrl};
        ADDR_CHSEL: next_prdata = {16'h0, chsel};
        ADDR_STAT: next_prdata = {27'h0, ext_on, st == CMCD_ST_FAILED, cause};
        ADDR_DISP: next_prdata = {16'h0, ind_single};
        default: next_prdata = 32'h00000000;
      endcase
    end
    if (psel && penable && pready && pwrite) begin
      if (paddr == ADDR_CTRL) next_ctrl = pwdata[1:0];
      if (paddr == ADDR_CHSEL) next_chsel = pwdata[NCH-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
      chsel <= CHSEL_RESET;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      ctrl <= next_ctrl;
      chsel <= next_chsel;
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  // ------------------------------------------------------------------
  // millisecond tick
  // ------------------------------------------------------------------
  logic [TICK_W-1:0] tick_cnt, next_tick_cnt;
  logic tick;

  always_comb begin
    tick = (tick_cnt == TICK_W'(TICK_CYCLES - 1));
    next_tick_cnt = tick ? '0 : tick_cnt + 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tick_cnt <= '0;
    else tick_cnt <= next_tick_cnt;
  end

  // ------------------------------------------------------------------
  // checks and persistence
  // ------------------------------------------------------------------
  logic [NCH-1:0] act, mult_ch, none_ch, gap_ch, last_grn, next_last_grn;
  logic conf, sf1_on;
  logic [NCLS-1:0] raw, qual;
  logic [8:0] cnt [NCLS];
  logic [8:0] next_cnt [NCLS];

  always_comb begin
    act = grn | yel;
    conf = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      for (int j = i + 1; j < NCH; j++) begin
        if (is_linked(link, i, j) && act[i] && act[j]) conf = 1'b1;
      end
    end
    ext_on = red_en && !(flash && st == CMCD_ST_RUN);
    sf1_on = (sf1_raw == ctrl[CTRL_SFPOL_BIT]);
    for (int i = 0; i < NCH; i++) begin
      mult_ch[i] = ext_on && chsel[i] && ((grn[i] && yel[i]) || (grn[i] && red[i]) ||
                   (yel[i] && red[i]));
      none_ch[i] = ext_on && chsel[i] && !(grn[i] || yel[i] || red[i]) && !sf1_on;
      gap_ch[i] = ext_on && chsel[i] && red[i] && last_grn[i];
      if (grn[i]) next_last_grn[i] = 1'b1;
      else if (yel[i] || red[i]) next_last_grn[i] = 1'b0;
      else next_last_grn[i] = last_grn[i];
    end
    raw = {|mult_ch, |none_ch, conf};
    for (int k = 0; k < NCLS; k++) begin
      qual[k] = (cnt[k] >= PERSIST_TICKS);
      if (!raw[k] || st == CMCD_ST_FAILED) next_cnt[k] = '0;
      else if (tick && !qual[k]) next_cnt[k] = cnt[k] + 1'b1;
      else next_cnt[k] = cnt[k];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_grn <= '0;
      for (int k = 0; k < NCLS; k++) cnt[k] <= '0;
    end else begin
      last_grn <= next_last_grn;
      for (int k = 0; k < NCLS; k++) cnt[k] <= next_cnt[k];
    end
  end

  // ------------------------------------------------------------------
  // failed state and indicators
  // ------------------------------------------------------------------
  logic [NCH-1:0] snap_r, snap_y, snap_g, mask;
  logic [NCH-1:0] next_snap_r, next_snap_y, next_snap_g, next_mask;
  logic [NCH-1:0] next_single, next_red, next_yellow, next_green;
  logic kind_b, next_kind_b, grp_a, grp_b, three;

  always_comb begin
    three = ctrl[CTRL_THREE_BIT];
    grp_a = dc_f || wdt_f || card_f || qual[0];
    grp_b = qual[1] || qual[2] || (|gap_ch);
    next_st = st;
    next_cause = cause;
    next_kind_b = kind_b;
    next_snap_r = snap_r;
    next_snap_y = snap_y;
    next_snap_g = snap_g;
    next_mask = mask;
    case (st)
      CMCD_ST_RUN: begin
        // capture inputs at fault, first group wins
        if (grp_a) begin
          next_st = CMCD_ST_FAILED;
          next_kind_b = 1'b0;
          next_snap_r = red;
          next_snap_y = yel;
          next_snap_g = grn;
          if (dc_f) next_cause = CMCD_CAUSE_DC;
          else if (wdt_f) next_cause = CMCD_CAUSE_WDT;
          else if (card_f) next_cause = CMCD_CAUSE_CARD;
          else next_cause = CMCD_CAUSE_CONFLICT;
        end else if (grp_b) begin
          next_st = CMCD_ST_FAILED;
          next_kind_b = 1'b1;
          if (qual[1]) begin
            next_cause = CMCD_CAUSE_NOOUT;
            next_mask = none_ch;
          end else if (qual[2]) begin
            next_cause = CMCD_CAUSE_MULT;
            next_mask = mult_ch;
          end else begin
            next_cause = CMCD_CAUSE_GAP;
            next_mask = gap_ch;
          end
        end
      end
      CMCD_ST_FAILED: if (ext_rst) next_st = CMCD_ST_RUN;
      default: next_st = CMCD_ST_RUN;
    endcase
    next_single = grn | yel;
    next_red = red;
    next_yellow = yel;
    next_green = grn;
    if (st == CMCD_ST_FAILED && !kind_b) begin
      next_single = snap_g | snap_y;
      next_red = snap_r;
      next_yellow = snap_y;
      next_green = snap_g;
    end else if (st == CMCD_ST_FAILED) begin
      next_single = mask;
      next_red = mask;
      next_yellow = mask;
      next_green = mask;
    end
    if (!three) begin
      next_red = '0;
      next_yellow = '0;
      next_green = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= CMCD_ST_RUN;
      cause <= CMCD_CAUSE_NONE;
      kind_b <= 1'b0;
      snap_r <= '0;
      snap_y <= '0;
      snap_g <= '0;
      mask <= '0;
      ind_single <= '0;
      ind_red <= '0;
      ind_yellow <= '0;
      ind_green <= '0;
      failed <= 1'b0;
    end else begin
      st <= next_st;
      cause <= next_cause;
      kind_b <= next_kind_b;
      snap_r <= next_snap_r;
      snap_y <= next_snap_y;
      snap_g <= next_snap_g;
      mask <= next_mask;
      ind_single <= next_single;
      ind_red <= next_red;
      ind_yellow <= next_yellow;
      ind_green <= next_green;
      failed <= (next_st == CMCD_ST_FAILED);
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_live_single;
    st == CMCD_ST_RUN |=> ind_single == $past(act);
  endproperty
  a_live_single: assert property (p_live_single) else $error("live indicator mismatch");

  property p_snap_shown;
    (st == CMCD_ST_RUN && grp_a) ##1 !ext_rst |=> ind_single == $past(act, 2);
  endproperty
  a_snap_shown: assert property (p_snap_shown) else $error("fault snapshot not shown");

  property p_mask_shown;
    st == CMCD_ST_FAILED && kind_b |=> ind_single == $past(mask);
  endproperty
  a_mask_shown: assert property (p_mask_shown) else $error("faulty channels not shown");

  property p_three_mask;
    st == CMCD_ST_FAILED && kind_b && three |=> ind_red == ind_green && ind_yellow == ind_green;
  endproperty
  a_three_mask: assert property (p_three_mask) else $error("three colours differ");

  property p_no_ext_without_enable;
    !red_en |-> raw[2:1] == 2'b00 && gap_ch == '0;
  endproperty
  a_no_ext_without_enable: assert property (p_no_ext_without_enable) else $error("ext check active");

  property p_preempt;
    sf1_on |-> none_ch == '0;
  endproperty
  a_preempt: assert property (p_preempt) else $error("no-output not suppressed");

  property p_conflict_min;
    st == CMCD_ST_RUN && next_cause == CMCD_CAUSE_CONFLICT && next_st == CMCD_ST_FAILED
      |-> cnt[0] >= 9'(CONFLICT_IGNORE_MS / TICK_MS);
  endproperty
  a_conflict_min: assert property (p_conflict_min) else $error("conflict failed too early");

  property p_conflict_fail;
    st == CMCD_ST_RUN && cnt[0] == PERSIST_TICKS |=> st == CMCD_ST_FAILED;
  endproperty
  a_conflict_fail: assert property (p_conflict_fail) else $error("qualified conflict ignored");

  property p_flash_gate;
    flash && st == CMCD_ST_RUN |-> !ext_on;
  endproperty
  a_flash_gate: assert property (p_flash_gate) else $error("flash did not gate ext");

  property p_hold;
    st == CMCD_ST_FAILED && !ext_rst ##1 st == CMCD_ST_FAILED |=> $stable(ind_single);
  endproperty
  a_hold: assert property (p_hold) else $error("snapshot changed while failed");

  c_conflict: cover property (st == CMCD_ST_RUN && qual[0]);
  c_noout: cover property (st == CMCD_ST_RUN && qual[1] && !grp_a);
  c_gap: cover property (st == CMCD_ST_RUN && (|gap_ch) && !grp_a);
  c_release: cover property (st == CMCD_ST_FAILED && ext_rst);

endmodule : cmcd_monitor
`default_nettype wire

//--- tb/cmcd_field_model.sv
/*
  Field side model: drives the sensed colour levels and the card links.
  Assumes a bench that calls its tasks from a process timed on pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module cmcd_field_model (
  // clock
  input wire logic pclk,
  // field levels and links
  output var logic [cmcd_pkg::NCH-1:0] green,
  output var logic [cmcd_pkg::NCH-1:0] yellow,
  output var logic [cmcd_pkg::NCH-1:0] red,
  output var logic [cmcd_pkg::NPAIR-1:0] link
);
  import cmcd_pkg::*;
  // dark field, no pair linked
  initial begin
    green = '0;
    yellow = '0;
    red = '0;
    link = '0;
  end
  // new lamp levels land just after an edge
  task automatic drive(input logic [NCH-1:0] g, input logic [NCH-1:0] y,
                       input logic [NCH-1:0] r);
    @(posedge pclk);
    green <= g;
    yellow <= y;
    red <= r;
  endtask : drive
  // links change the same way
  task automatic set_link(input logic [NPAIR-1:0] l);
    @(posedge pclk);
    link <= l;
  endtask : set_link
endmodule : cmcd_field_model
`default_nettype wire

//--- tb/conflict_monitor_channel_display_tb.sv
/*
  Self-checking bench: registers, then live display table, conflict timing,
  fault snapshots and extended checks. Assumes the field model is compiled.
*/
`timescale 1ns/1ps
`default_nettype none
module conflict_monitor_channel_display_tb;
  import cmcd_pkg::*;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  localparam int TK = 4;
  localparam int FAIL_CYC = CONFLICT_FAIL_MS * TK + 20;
  localparam int IGN_CYC = CONFLICT_IGNORE_MS * TK;
  localparam int LIMIT = 30000;
  typedef struct {
    logic three;
    logic [15:0] g, y, r, s, er, ey, eg;
  } cmcd_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, errv;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [NCH-1:0] green, yellow, red, ind_single, ind_red, ind_yellow, ind_green;
  logic [NPAIR-1:0] link;
  logic red_enable, preempt, flash, dc, wdt, card, ext_rst, failed;
  int mismatches, check_count, cyc;
  cmcd_cause_t fcause [3] = '{CMCD_CAUSE_DC, CMCD_CAUSE_WDT, CMCD_CAUSE_CARD};
  cmcd_row_t rows [5] = '{
    '{1'b0, 16'h0001, 16'h0000, 16'h0000, 16'h0001, 16'h0, 16'h0, 16'h0},
    '{1'b0, 16'h0000, 16'h8000, 16'h0001, 16'h8000, 16'h0, 16'h0, 16'h0},
    '{1'b0, 16'hAAAA, 16'h5500, 16'h0000, 16'hFFAA, 16'h0, 16'h0, 16'h0},
    '{1'b1, 16'h000F, 16'h00F0, 16'hFF00, 16'h0, 16'hFF00, 16'h00F0, 16'h000F},
    '{1'b1, 16'h1234, 16'h0000, 16'h4321, 16'h0, 16'h4321, 16'h0000, 16'h1234}};
  // clock and hang guard
  initial pclk = 1'b0;
  always #50 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == LIMIT) begin
      mismatches++;
      close_out();
    end
  end
  cmcd_field_model field_u (.pclk(pclk), .green(green), .yellow(yellow), .red(red),
    .link(link));
  cmcd_monitor #(.TICK_CYCLES(TK)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .green_in(green), .yellow_in(yellow),
    .red_in(red), .card_link(link), .red_enable(red_enable),
    .preempt_inhibit_in(preempt), .flash_relay_sense(flash),
    .dc_supply_fault(dc), .watchdog_timeout_fault(wdt),
    .card_unseated_fault(card), .external_reset(ext_rst),
    .ind_single(ind_single), .ind_red(ind_red), .ind_yellow(ind_yellow),
    .ind_green(ind_green), .failed(failed));
  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] e);
    check_count++;
    if (seen !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, seen);
    end
  endtask : check
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the cycle ceiling ends a wait for the slave
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(n, rdv, e);
  endtask : rd_chk
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : wait_cyc
  // drop every fault cause and raise external reset on the same edge, then release it
  task automatic clear();
    field_u.drive('0, '0, '0);
    {dc, wdt, card} <= 3'b000;
    ext_rst <= 1'b1;
    wait_cyc(5);
    ext_rst <= 1'b0;
    wait_cyc(5);
  endtask : clear
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  // ------------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, red_enable, preempt, flash} = '0;
    {dc, wdt, card, ext_rst} = '0;
    paddr = '0;
    pwdata = '0;
    mismatches = 0;
    check_count = 0;
    cyc = 0;
    wait_cyc(10);
    check("reset outputs", {failed, pready, ind_single}, 32'h0);
    presetn <= 1'b1;
    rd_chk("ctrl", ADDR_CTRL, 32'(CTRL_RESET));
    rd_chk("chsel", ADDR_CHSEL, 32'(CHSEL_RESET));
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped err", errv, 32'h1);
    check("unmapped data", rdv, 32'h0);
    apb(1'b1, ADDR_STAT, 32'hFFFF_FFFF);
    rd_chk("stat", ADDR_STAT, 32'h0);
    apb(1'b1, ADDR_CHSEL, 32'hFFFF_FFFF);
    rd_chk("chsel", ADDR_CHSEL, 32'h0000_FFFF);
    apb(1'b1, ADDR_CTRL, 32'hFFFF_FFFF);
    rd_chk("ctrl", ADDR_CTRL, 32'h3);
    foreach (rows[i]) begin
      apb(1'b1, ADDR_CTRL, {31'h0, rows[i].three});
      field_u.drive(rows[i].g, rows[i].y, rows[i].r);
      wait_cyc(6);
      if (rows[i].three == 1'b0) begin
        check("single", ind_single, rows[i].s);
        rd_chk("disp", ADDR_DISP, {16'h0, rows[i].s});
      end
      check("red", ind_red, rows[i].er);
      check("yellow", ind_yellow, rows[i].ey);
      check("green", ind_green, rows[i].eg);
    end
    apb(1'b1, ADDR_CTRL, 32'h0);
    field_u.set_link(120'h1);
    field_u.drive(16'h0003, '0, '0);
    wait_cyc(IGN_CYC - 1);
    field_u.drive('0, '0, '0);
    wait_cyc(10);
    check("short conflict", failed, 32'h0);
    field_u.set_link('0);
    field_u.drive(16'h0003, '0, '0);
    wait_cyc(FAIL_CYC);
    check("unlinked pair", failed, 32'h0);
    field_u.set_link(120'h1);
    wait_cyc(FAIL_CYC);
    check("long conflict", failed, 32'h1);
    rd_chk("stat", ADDR_STAT, 32'h0000_000A);
    check("snapshot", ind_single, 32'h0003);
    field_u.drive(16'h0F00, '0, '0);
    wait_cyc(10);
    check("snapshot hold", ind_single, 32'h0003);
    field_u.set_link('0);
    clear();
    check("cleared", failed, 32'h0);
    for (int k = 0; k < 3; k++) begin
      field_u.drive(16'h0010 << k, '0, '0);
      wait_cyc(5);
      {card, wdt, dc} <= 3'b001 << k;
      wait_cyc(6);
      check("failed", failed, 32'h1);
      check("snap", ind_single, 32'h10 << k);
      rd_chk("cause", ADDR_STAT, 32'h8 | 32'(fcause[k]));
      field_u.drive(16'h8000, '0, '0);
      wait_cyc(6);
      check("hold", ind_single, 32'h10 << k);
      clear();
    end
    apb(1'b1, ADDR_CHSEL, 32'h1);
    wait_cyc(FAIL_CYC);
    check("basic only", failed, 32'h0);
    // cause of the last fault (card) stays readable after the clear
    rd_chk("stat", ADDR_STAT, 32'h4);
    red_enable <= 1'b1;
    flash <= 1'b1;
    wait_cyc(FAIL_CYC);
    check("flash", failed, 32'h0);
    flash <= 1'b0;
    preempt <= 1'b1;
    apb(1'b1, ADDR_CTRL, 32'h2);
    rd_chk("stat", ADDR_STAT, 32'h14);
    wait_cyc(FAIL_CYC);
    check("inhibit high", failed, 32'h0);
    preempt <= 1'b0;
    apb(1'b1, ADDR_CTRL, 32'h0);
    wait_cyc(FAIL_CYC);
    check("inhibit low", failed, 32'h0);
    // yellow alone first, so channel 0 leaves its last green without a gap
    field_u.drive('0, 16'h1, '0);
    wait_cyc(5);
    check("yellow only", failed, 32'h0);
    field_u.drive('0, 16'h1, 16'h1);
    wait_cyc(FAIL_CYC);
    check("multiple", failed, 32'h1);
    apb(1'b0, ADDR_STAT, 32'h0);
    check("cause", rdv & 32'hF, 32'hE);
    check("faulty only", ind_single, 32'h1);
    clear();
    preempt <= 1'b1;
    apb(1'b1, ADDR_CTRL, 32'h1);
    field_u.drive(16'h4, '0, '0);
    wait_cyc(FAIL_CYC);
    check("no output", failed, 32'h1);
    apb(1'b0, ADDR_STAT, 32'h0);
    check("cause", rdv & 32'hF, 32'hD);
    check("red", ind_red, 32'h1);
    check("yellow", ind_yellow, 32'h1);
    check("green", ind_green, 32'h1);
    clear();
    // amber gap, green straight to red
    apb(1'b1, ADDR_CTRL, 32'h0);
    field_u.drive(16'h5, '0, '0);
    wait_cyc(10);
    field_u.drive(16'h4, '0, 16'h1);
    wait_cyc(6);
    check("gap", failed, 32'h1);
    apb(1'b0, ADDR_STAT, 32'h0);
    check("cause", rdv & 32'hF, 32'hF);
    check("faulty only", ind_single, 32'h1);
    close_out();
  end
endmodule : conflict_monitor_channel_display_tb
`default_nettype wire
